//--- verilog/pbd_channel.sv
// Purpose: Push-button channel with value adjustment, bus-return reaction
//          and per-function disabling, sending telegrams as object values
// Assumes: Inputs synchronous to pclk; presetn low models bus voltage loss
// Notes:   One telegram leaves per cycle; later ones wait in pending slots
`timescale 1ns/1ps
`default_nettype none

module pbd_channel
    import pbd_pkg::*;
#(
    parameter int unsigned CYC_PER_MS = ONE_MS_NS / CLK_PERIOD_NS
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        button,
    input  wire logic [1:0]  sw_disable_obj,
    input  wire logic        dim_disable_obj,
    input  wire logic        blind_disable_obj,
    output logic             tx_valid,
    output logic      [1:0]  tx_obj,
    output logic      [15:0] tx_value
);

    typedef enum logic [1:0] {ST_DELAY, ST_REACT, ST_RUN} pbd_start_t;

    logic [31:0] ctrl;
    logic [31:0] values;
    logic [31:0] dis_cfg;
    logic [15:0] delay_ms;

    // Configuration fields
    pbd_func_t   func;
    pbd_edge_t   edge_mode;
    pbd_ret_t    ret_react;
    logic        adj_en;
    logic [1:0]  base_sel;
    logic [6:0]  factor;
    logic [15:0] rise_val;
    logic [15:0] fall_val;
    logic        sw_en;
    logic        sw_inv;
    logic [1:0]  sw_begin;
    logic [1:0]  sw_end;
    logic        dim_en;
    logic        dim_inv;
    logic [1:0]  dim_begin;
    logic        dim_end_off;
    logic        blind_en;
    logic        blind_inv;
    logic [1:0]  sw_rise_cmd;
    logic [1:0]  sw_fall_cmd;

    assign func        = pbd_func_t'(ctrl[1:0]);
    assign edge_mode   = pbd_edge_t'(ctrl[3:2]);
    assign adj_en      = ctrl[4];
    assign ret_react   = pbd_ret_t'(ctrl[6:5]);
    assign base_sel    = ctrl[8:7];
    assign factor      = ctrl[15:9];
    assign rise_val    = values[15:0];
    assign fall_val    = values[31:16];
    assign sw_en       = dis_cfg[0];
    assign sw_inv      = dis_cfg[1];
    assign sw_begin    = dis_cfg[3:2];
    assign sw_end      = dis_cfg[5:4];
    assign dim_en      = dis_cfg[6];
    assign dim_inv     = dis_cfg[7];
    assign dim_begin   = dis_cfg[9:8];
    assign dim_end_off = dis_cfg[10];
    assign blind_en    = dis_cfg[11];
    assign blind_inv   = dis_cfg[12];
    assign sw_rise_cmd = dis_cfg[15:14];
    assign sw_fall_cmd = dis_cfg[17:16];

    // Returns {send, value} for a switching command on an object
    function automatic logic [1:0] apply_cmd(input logic [1:0] cmd,
                                             input logic       cur);
        case (cmd)
            CMD_ON:     apply_cmd = 2'b11;
            CMD_OFF:    apply_cmd = 2'b10;
            CMD_TOGGLE: apply_cmd = {1'b1, ~cur};
            default:    apply_cmd = {1'b0, cur};
        endcase
    endfunction

    // APB slave: zero wait states, read data captured in the setup phase
    logic apb_wr;
    logic apb_setup;
    logic addr_ok;
    logic [1:0]  sw_val;
    logic        dim_val;
    logic [3:0]  dis_now;
    logic        start_done;
    logic [15:0] brt_cur;

    assign pready    = 1'b1;
    assign apb_wr    = psel & penable & pwrite;
    assign apb_setup = psel & ~penable;
    assign addr_ok   = (paddr == OFS_CTRL)  || (paddr == OFS_VALUES) ||
                       (paddr == OFS_DIS)   || (paddr == OFS_DELAY)  ||
                       (paddr == OFS_STATUS);

    // Software-written configuration
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl     <= RST_CTRL;
            values   <= RST_VALUES;
            dis_cfg  <= RST_DIS;
            delay_ms <= RST_DELAY;
        end else if (apb_wr) begin
            case (paddr)
                OFS_CTRL:   ctrl     <= pwdata;
                OFS_VALUES: values   <= pwdata;
                OFS_DIS:    dis_cfg  <= pwdata;
                OFS_DELAY:  delay_ms <= pwdata[15:0];
                default:    ;
            endcase
        end
    end

    // Read data and error flag, held through the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (apb_setup) begin
            pslverr <= ~addr_ok;
            case (paddr)
                OFS_CTRL:   prdata <= ctrl;
                OFS_VALUES: prdata <= values;
                OFS_DIS:    prdata <= dis_cfg;
                OFS_DELAY:  prdata <= {16'h0000, delay_ms};
                OFS_STATUS: prdata <= {brt_cur, 8'h00, start_done,
                                       dis_now, dim_val, sw_val};
                default:    prdata <= 32'h0000_0000;
            endcase
        end
    end

    // Millisecond tick shared by every timer
    logic [31:0] ms_cnt;
    logic        ms_tick;
    assign ms_tick = (ms_cnt == CYC_PER_MS - 1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ms_cnt <= 32'h0000_0000;
        end else begin
            ms_cnt <= ms_tick ? 32'h0000_0000 : ms_cnt + 32'h0000_0001;
        end
    end

    // Input edges
    logic btn_prev;
    logic btn_rise;
    logic btn_fall;
    assign btn_rise = button & ~btn_prev;
    assign btn_fall = ~button & btn_prev;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            btn_prev <= 1'b0;
        end else begin
            btn_prev <= button;
        end
    end

    // Start-up delay after bus return, then one reaction
    pbd_start_t  start_st;
    logic [15:0] delay_cnt;
    logic        ret_fire;
    assign ret_fire   = (start_st == ST_REACT);
    assign start_done = (start_st == ST_RUN);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_st  <= ST_DELAY;
            delay_cnt <= 16'h0000;
        end else begin
            case (start_st)
                ST_DELAY: begin
                    if (delay_cnt >= delay_ms) begin
                        start_st <= ST_REACT;
                    end else if (ms_tick) begin
                        delay_cnt <= delay_cnt + 16'h0001;
                    end
                end
                ST_REACT: start_st <= ST_RUN;
                ST_RUN:   start_st <= ST_RUN;
                default:  start_st <= ST_DELAY;
            endcase
        end
    end

    // Effective disable states with polarity; blind only reports its state
    logic [1:0] sw_dis;
    logic       dim_dis;
    logic       blind_dis;
    logic [1:0] sw_dis_prev;
    logic       dim_dis_prev;
    assign sw_dis    = {2{sw_en}} & (sw_disable_obj ^ {2{sw_inv}});
    assign dim_dis   = dim_en & (dim_disable_obj ^ dim_inv);
    assign blind_dis = blind_en & (blind_disable_obj ^ blind_inv);
    assign dis_now   = {blind_dis, dim_dis, sw_dis};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_dis_prev  <= 2'b00;
            dim_dis_prev <= 1'b0;
        end else begin
            sw_dis_prev  <= sw_dis;
            dim_dis_prev <= dim_dis;
        end
    end

    // Send requests into the pending slots
    logic [N_OBJ-1:0] set_req;
    logic [15:0]      set_val [N_OBJ];

    // Switching objects 1.1 and 1.2, each with its own disable edges
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_sw
            logic [1:0] res;
            logic [1:0] inp_cmd;
            assign inp_cmd = button ? sw_rise_cmd : sw_fall_cmd;
            always_comb begin
                res = 2'b00;
                if (sw_dis[gi] && !sw_dis_prev[gi]) begin
                    res = apply_cmd(sw_begin, sw_val[gi]);
                end else if (!sw_dis[gi] && sw_dis_prev[gi]) begin
                    if (sw_end == CMD_TOGGLE) begin
                        res = apply_cmd(inp_cmd, sw_val[gi]);
                    end else begin
                        res = apply_cmd(sw_end, sw_val[gi]);
                    end
                end else if (func == FN_SWITCH && !sw_dis[gi]) begin
                    if (btn_rise) begin
                        res = apply_cmd(sw_rise_cmd, sw_val[gi]);
                    end else if (btn_fall) begin
                        res = apply_cmd(sw_fall_cmd, sw_val[gi]);
                    end
                end
            end
            assign set_req[gi] = res[1];
            assign set_val[gi] = {15'h0000, res[0]};

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sw_val[gi] <= 1'b0;
                end else if (res[1]) begin
                    sw_val[gi] <= res[0];
                end
            end
        end
    endgenerate

    // Dimming switching object
    logic [1:0] dim_res;
    always_comb begin
        dim_res = 2'b00;
        if (dim_dis && !dim_dis_prev) begin
            dim_res = apply_cmd(dim_begin, dim_val);
        end else if (!dim_dis && dim_dis_prev) begin
            dim_res = {dim_end_off, 1'b0};
        end else if (func == FN_DIM && !dim_dis && btn_rise) begin
            dim_res = {1'b1, ~dim_val};
        end
    end
    assign set_req[OBJ_DIM] = dim_res[1];
    assign set_val[OBJ_DIM] = {15'h0000, dim_res[0]};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dim_val <= 1'b0;
        end else if (dim_res[1]) begin
            dim_val <= dim_res[0];
        end
    end

    // Brightness transmitter; the held value survives after adjusting
    logic        act;
    logic        act_edge;
    logic        brt_sel;
    logic        adj_ok;
    logic        adj_used;
    logic        adj_up;
    logic [15:0] adj_val;
    logic [15:0] hold_ms;
    logic [16:0] per_ms;
    logic [16:0] per_cnt;
    logic [9:0]  base_ms;
    logic        long_on;
    logic        step;
    logic [15:0] stepped;
    logic        ret_send;
    logic [15:0] ret_val;

    assign brt_sel  = (func == FN_BRIGHT) && start_done;
    assign act      = (edge_mode == ON_FALL) ? ~button : button;
    assign act_edge = (edge_mode == ON_FALL) ? btn_fall : btn_rise;
    assign adj_ok   = adj_en && (edge_mode == ON_RISE || edge_mode == ON_FALL);
    assign brt_cur  = adj_used ? adj_val
                    : ((edge_mode == ON_FALL) ? fall_val : rise_val);
    assign long_on  = (hold_ms >= LONG_PRESS_MS[15:0]);

    always_comb begin
        case (base_sel)
            2'd0:    base_ms = BASE_130;
            2'd1:    base_ms = BASE_260;
            default: base_ms = BASE_520;
        endcase
    end
    assign per_ms = 17'(base_ms) * 17'(factor);
    // First step as the hold reaches the long-press boundary, then per period
    assign step = brt_sel && adj_ok && act && ms_tick &&
                  (long_on ? (per_cnt + 17'd1 >= per_ms)
                           : (hold_ms == LONG_PRESS_MS[15:0] - 16'h0001));

    always_comb begin
        if (adj_up) begin
            stepped = (brt_cur >= LUX_MAX - LUX_STEP) ? LUX_MAX
                    : brt_cur + LUX_STEP;
        end else begin
            stepped = (brt_cur <= LUX_STEP) ? 16'h0000
                    : brt_cur - LUX_STEP;
        end
    end

    // Hold timer and step period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_ms <= 16'h0000;
            per_cnt <= 17'h0_0000;
        end else if (!act || !brt_sel) begin
            hold_ms <= 16'h0000;
            per_cnt <= 17'h0_0000;
        end else if (ms_tick) begin
            if (!long_on) begin
                hold_ms <= hold_ms + 16'h0001;
            end
            per_cnt <= step ? 17'h0_0000 : per_cnt + 17'h0_0001;
        end
    end

    // Adjusted value and direction; direction flips at each release after a long press
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            adj_val  <= 16'h0000;
            adj_used <= 1'b0;
            adj_up   <= 1'b1;
        end else begin
            if (step) begin
                adj_val  <= stepped;
                adj_used <= 1'b1;
            end
            if (brt_sel && !act && long_on) begin
                adj_up <= ~adj_up;
            end
        end
    end

    // Bus-return reaction, honouring which edges the mode offers
    always_comb begin
        ret_send = 1'b0;
        ret_val  = 16'h0000;
        case (ret_react)
            RET_RISE: begin
                ret_send = (edge_mode == ON_RISE || edge_mode == ON_BOTH);
                ret_val  = rise_val;
            end
            RET_FALL: begin
                ret_send = (edge_mode == ON_FALL || edge_mode == ON_BOTH);
                ret_val  = fall_val;
            end
            RET_INPUT: begin
                ret_send = (edge_mode == ON_BOTH);
                ret_val  = button ? rise_val : fall_val;
            end
            default: ;
        endcase
    end

    logic        brt_req;
    logic [15:0] brt_val;
    always_comb begin
        brt_req = 1'b0;
        brt_val = brt_cur;
        if (ret_fire && ret_send && func == FN_BRIGHT) begin
            brt_req = 1'b1;
            brt_val = ret_val;
        end else if (step) begin
            brt_req = 1'b1;
            brt_val = stepped;
        end else if (brt_sel && edge_mode == ON_BOTH) begin
            brt_req = btn_rise | btn_fall;
            brt_val = btn_rise ? rise_val : fall_val;
        end else if (brt_sel && act_edge) begin
            brt_req = 1'b1;
        end
    end
    assign set_req[OBJ_BRT] = brt_req;
    assign set_val[OBJ_BRT] = brt_val;

    // Pending slots: a new request in the grant cycle stays pending
    logic [N_OBJ-1:0] pend;
    logic [15:0]      pend_val [N_OBJ];
    logic [N_OBJ-1:0] grant;
    logic [1:0]       grant_idx;

    always_comb begin
        grant     = '0;
        grant_idx = OBJ_SW1;
        for (int k = N_OBJ - 1; k >= 0; k--) begin
            if (pend[k]) begin
                grant     = '0;
                grant[k]  = 1'b1;
                grant_idx = 2'(k);
            end
        end
    end

    generate
        for (gi = 0; gi < N_OBJ; gi++) begin : g_pend
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pend[gi]     <= 1'b0;
                    pend_val[gi] <= 16'h0000;
                end else if (set_req[gi]) begin
                    pend[gi]     <= 1'b1;
                    pend_val[gi] <= set_val[gi];
                end else if (grant[gi]) begin
                    pend[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // Telegram output, one per cycle, lowest object first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_valid <= 1'b0;
            tx_obj   <= OBJ_SW1;
            tx_value <= 16'h0000;
        end else begin
            tx_valid <= |pend;
            if (|pend) begin
                tx_obj   <= grant_idx;
                tx_value <= pend_val[grant_idx];
            end
        end
    end

endmodule

`default_nettype wire

//--- verilog/pbd_pkg.sv
// Purpose: Shared constants and types for the push-button channel block
// Assumes: 100 MHz pclk, APB register access with 32-bit data
// Notes:   Offsets are byte addresses; timer settings are kept in milliseconds, clock figures in ns
package pbd_pkg;

    // Clock and time base
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned ONE_MS_NS     = 1_000_000;
    localparam int unsigned LONG_PRESS_MS = 400;     // Short/long boundary

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_VALUES = 8'h04;
    localparam logic [7:0] OFS_DIS    = 8'h08;
    localparam logic [7:0] OFS_DELAY  = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;

    // Reset values
    localparam logic [31:0] RST_CTRL   = 32'h0000_0700; // 520 ms x 3
    localparam logic [31:0] RST_VALUES = 32'h0000_00C8; // Rise 200, fall 0
    localparam logic [31:0] RST_DIS    = 32'h0000_0000;
    localparam logic [15:0] RST_DELAY  = 16'h0000;

    // Brightness stepping in lux
    localparam logic [15:0] LUX_STEP = 16'h0032;     // 50 lux, fixed
    localparam logic [15:0] LUX_MAX  = 16'h05DC;     // 1500 lux

    // Time base choices in ms
    localparam logic [9:0] BASE_130 = 10'h082;
    localparam logic [9:0] BASE_260 = 10'h104;
    localparam logic [9:0] BASE_520 = 10'h208;

    // Channel function selection
    typedef enum logic [1:0] {
        FN_SWITCH, FN_DIM, FN_BLIND, FN_BRIGHT
    } pbd_func_t;

    // Edge on which a brightness value is sent
    typedef enum logic [1:0] {
        ON_RISE, ON_FALL, ON_BOTH, ON_RSVD
    } pbd_edge_t;

    // Bus-return reaction
    typedef enum logic [1:0] {
        RET_NONE, RET_RISE, RET_FALL, RET_INPUT
    } pbd_ret_t;

    // Switching commands; code 3 means toggle or input state by context
    typedef enum logic [1:0] {
        CMD_NONE, CMD_ON, CMD_OFF, CMD_TOGGLE
    } pbd_cmd_t;

    // Telegram objects, also pending-slot indices
    localparam int unsigned N_OBJ     = 4;
    localparam logic [1:0]  OBJ_SW1   = 2'h0;
    localparam logic [1:0]  OBJ_SW2   = 2'h1;
    localparam logic [1:0]  OBJ_DIM   = 2'h2;
    localparam logic [1:0]  OBJ_BRT   = 2'h3;

endpackage

//--- sim/pbd_channel_sva.sv
// Purpose: Port checks on the push-button channel
// Assumes: Disable settings are mirrored from APB writes to DIS
// Notes:   Windows allow for other slots queued ahead of a telegram
`timescale 1ns/1ps
`default_nettype none

module pbd_channel_chk
    import pbd_pkg::*;
#(
    parameter int unsigned CYC_PER_MS = 10
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [1:0]  sw_disable_obj,
    input wire logic        dim_disable_obj,
    input wire logic        tx_valid,
    input wire logic [1:0]  tx_obj,
    input wire logic [15:0] tx_value
);
    logic [17:0] dis;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Mirror of DIS; changes only where the write really lands
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dis <= RST_DIS[17:0];
        end else if (psel && penable && pwrite && pready && paddr == OFS_DIS) begin
            dis <= pwdata[17:0];
        end
    end

    chk_sw_binary: assert property (
        tx_valid && tx_obj != OBJ_BRT |-> tx_value <= 16'h0001)
        else $error("switching value out of range");
    chk_lux_grid: assert property (
        tx_valid && tx_obj == OBJ_BRT
        |-> tx_value % LUX_STEP == 16'h0000 && tx_value <= LUX_MAX)
        else $error("brightness off the step grid");
    chk_boot_quiet: assert property (
        $rose(presetn) |-> !tx_valid [*8])
        else $error("telegram after bus return with no reaction");
    chk_dim_begin: assert property (
        dis[6] && !dis[7] && dis[9:8] == CMD_ON && $rose(dim_disable_obj)
        |-> ##[1:8] (tx_valid && tx_obj == OBJ_DIM && tx_value == 16'h0001))
        else $error("dimming disable start not sent");
    chk_dim_end: assert property (
        dis[6] && !dis[7] && dis[10] && $fell(dim_disable_obj)
        |-> ##[1:8] (tx_valid && tx_obj == OBJ_DIM && tx_value == 16'h0000))
        else $error("dimming disable end not sent");
    chk_sw_begin: assert property (
        dis[0] && !dis[1] && dis[3:2] == CMD_ON && $rose(sw_disable_obj[0])
        |-> ##[1:8] (tx_valid && tx_obj == OBJ_SW1 && tx_value == 16'h0001))
        else $error("switching disable start not sent");
    chk_sw_end: assert property (
        dis[0] && !dis[1] && dis[5:4] == CMD_OFF && $fell(sw_disable_obj[0])
        |-> ##[1:8] (tx_valid && tx_obj == OBJ_SW1 && tx_value == 16'h0000))
        else $error("switching disable end not sent");
    chk_sw_invert: assert property (
        dis[0] && dis[1] && dis[3:2] == CMD_TOGGLE && $fell(sw_disable_obj[1])
        |-> ##[1:8] (tx_valid && tx_obj == OBJ_SW2))
        else $error("inverted disable start not sent");
    cover property ($rose(sw_disable_obj[0]));
    cover property ($fell(dim_disable_obj));
    cover property (tx_valid && tx_obj == OBJ_BRT);
endmodule

bind pbd_channel pbd_channel_chk #(.CYC_PER_MS(CYC_PER_MS)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .sw_disable_obj(sw_disable_obj), .dim_disable_obj(dim_disable_obj),
    .tx_valid(tx_valid), .tx_obj(tx_obj), .tx_value(tx_value)
);

`default_nettype wire

//--- sim/pbd_bus_model.sv
// Purpose: Bus side model logging each telegram with its arrival cycle
// Assumes: One telegram per cycle with tx_valid high
// Notes:   Stands for every listener at once and never refuses
`timescale 1ns/1ps
`default_nettype none

module pbd_bus_model (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        tx_valid,
    input wire logic [1:0]  tx_obj,
    input wire logic [15:0] tx_value
);
    logic [31:0] cycle;
    logic [49:0] log_q[$];

    // Cycle stamp lets the bench judge telegram spacing
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cycle <= 32'h0000_0000;
        end else begin
            cycle <= cycle + 32'h0000_0001;
            if (tx_valid === 1'b1) begin
                log_q.push_back({cycle, tx_obj, tx_value});
            end
        end
    end
endmodule

`default_nettype wire

//--- sim/tb_top.sv
// Purpose: Self-checking bench for the push-button channel
// Assumes: CYC_PER_MS is 10, so one ms lasts ten pclk cycles
// Notes:   Telegrams are judged in order from the bus model's log
`timescale 1ns/1ps
`default_nettype none

module tb_top
    import pbd_pkg::*;
;
    logic        pclk = 1'b0;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        button;
    logic [1:0]  sw_disable_obj;
    logic        dim_disable_obj;
    logic        blind_disable_obj;
    logic        tx_valid;
    logic [1:0]  tx_obj;
    logic [15:0] tx_value;
    int          failures = 0;
    int          check_count = 0;

    always #5 pclk = ~pclk;
    pbd_channel #(.CYC_PER_MS(10)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .button(button),
        .sw_disable_obj(sw_disable_obj), .dim_disable_obj(dim_disable_obj),
        .blind_disable_obj(blind_disable_obj), .tx_valid(tx_valid),
        .tx_obj(tx_obj), .tx_value(tx_value)
    );

    pbd_bus_model bus_m (
        .pclk(pclk), .presetn(presetn), .tx_valid(tx_valid),
        .tx_obj(tx_obj), .tx_value(tx_value)
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        chk(r, exp);
    endtask

    // Bounded wait for the next logged telegram, then compare it
    task automatic expect_tx(input logic [17:0] exp, output logic [31:0] t);
        int          n;
        logic [49:0] e;
        n = 0;
        while (bus_m.log_q.size() == 0 && n < 6000) begin
            @(posedge pclk);
            n++;
        end
        e = (bus_m.log_q.size() > 0) ? bus_m.log_q.pop_front() : '1;
        chk({14'h0000, e[17:0]}, {14'h0000, exp});
        t = e[49:18];
    endtask

    // Nothing further may reach the bus
    task automatic quiet();
        repeat (40) @(posedge pclk);
        chk(32'(bus_m.log_q.size()), 32'h0000_0000);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Whole run needs under 10k cycles; this limit is generous
    initial begin
        repeat (60000) @(posedge pclk);
        failures++;
        finish_test();
    end

    initial begin
        logic [31:0] r;
        logic [31:0] t1;
        logic [31:0] t2;
        logic        e;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        button = 1'b0;
        sw_disable_obj = 2'b00;
        dim_disable_obj = 1'b0;
        blind_disable_obj = 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd(OFS_CTRL, RST_CTRL);
        rd(OFS_VALUES, RST_VALUES);
        rd(OFS_DIS, RST_DIS);
        rd(OFS_DELAY, {16'h0000, RST_DELAY});
        apb(1'b0, 8'h14, 32'h0000_0000, r, e);
        chk({31'h0000_0000, e}, 32'h0000_0001);
        quiet();
        $display("test reset done");
        // Brightness, rise mode, adjust on, 130 ms base, factor 1
        wr(OFS_CTRL, 32'h0000_0213);
        @(posedge pclk);
        button <= 1'b1;
        expect_tx({OBJ_BRT, RST_VALUES[15:0]}, t1);
        expect_tx({OBJ_BRT, RST_VALUES[15:0] + LUX_STEP}, t1);
        expect_tx({OBJ_BRT, RST_VALUES[15:0] + LUX_STEP + LUX_STEP}, t2);
        chk(t2 - t1, 32'(BASE_130) * 32'h0000_000A);
        @(posedge pclk);
        button <= 1'b0;
        quiet();
        $display("test adjust done");
        // Switching: begin on, end off, rise sends on
        wr(OFS_CTRL, RST_CTRL);
        wr(OFS_DIS, 32'h0000_4025);
        @(posedge pclk);
        sw_disable_obj <= 2'b01;
        expect_tx({OBJ_SW1, 16'h0001}, t1);
        @(posedge pclk);
        button <= 1'b1;
        expect_tx({OBJ_SW2, 16'h0001}, t1);
        @(posedge pclk);
        button <= 1'b0;
        quiet();
        @(posedge pclk);
        sw_disable_obj <= 2'b00;
        expect_tx({OBJ_SW1, 16'h0000}, t1);
        // Inverted polarity: begin toggle, end input state
        wr(OFS_DIS, 32'h0000_4000);
        @(posedge pclk);
        sw_disable_obj <= 2'b11;
        wr(OFS_DIS, 32'h0000_403F);
        quiet();
        @(posedge pclk);
        sw_disable_obj <= 2'b01;
        expect_tx({OBJ_SW2, 16'h0000}, t1);
        @(posedge pclk);
        button <= 1'b1;
        expect_tx({OBJ_SW1, 16'h0001}, t1);
        @(posedge pclk);
        sw_disable_obj <= 2'b11;
        expect_tx({OBJ_SW2, 16'h0001}, t1);
        @(posedge pclk);
        button <= 1'b0;
        quiet();
        $display("test switching done");
        // Dimming: begin on, end off, presses dropped meanwhile
        wr(OFS_DIS, 32'h0000_0540);
        wr(OFS_CTRL, RST_CTRL | 32'h0000_0001);
        @(posedge pclk);
        dim_disable_obj <= 1'b1;
        expect_tx({OBJ_DIM, 16'h0001}, t1);
        @(posedge pclk);
        button <= 1'b1;
        @(posedge pclk);
        button <= 1'b0;
        quiet();
        @(posedge pclk);
        dim_disable_obj <= 1'b0;
        expect_tx({OBJ_DIM, 16'h0000}, t1);
        @(posedge pclk);
        button <= 1'b1;
        expect_tx({OBJ_DIM, 16'h0001}, t1);
        @(posedge pclk);
        button <= 1'b0;
        // Blind disable only shows in status
        wr(OFS_DIS, 32'h0000_0800);
        @(posedge pclk);
        blind_disable_obj <= 1'b1;
        quiet();
        apb(1'b0, OFS_STATUS, 32'h0000_0000, r, e);
        chk({31'h0000_0000, r[6]}, 32'h0000_0001);
        $display("test dimming done");
        finish_test();
    end
endmodule

`default_nettype wire
